// >>> flash_host_pkg.sv
package flash_host_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // Operation codes in CTRL[2:0]
  localparam logic [2:0] OP_WRITE = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_SUSPEND = 3'h2;
  localparam logic [2:0] OP_RESUME = 3'h3;
  localparam logic [2:0] OP_POLL = 3'h4;

  // Command data values
  localparam logic [7:0] RESUME_CODE = 8'h30;

  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_SUSP = 3;
  localparam int ST_RDY = 4;
  localparam int ST_TMO = 5;
  localparam int ST_DATA_LSB = 8;

  // Status bit positions inside a flash status byte
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TMO_BIT = 5;

  // Reset values
  localparam logic [19:0] ADDR_RST = 20'h0_0000;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Bus cycle timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_WE_LOW_NS = 35;
  localparam int T_WE_HIGH_NS = 20;
  localparam int T_ACCESS_NS = 90;
  localparam int T_OE_HIGH_NS = 20;
  localparam int SYNC_STAGES = 2;
  localparam int WE_LOW_CYC = (T_WE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WE_HIGH_CYC = (T_WE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCESS_CYC = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_STAGES;
  localparam int OE_HIGH_CYC = (T_OE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum {
    S_IDLE,
    S_WR_LO,
    S_WR_HI,
    S_RD_LO,
    S_RD_HI,
    S_EVAL
  } host_state_e;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
  } flash_ctl_s;

  localparam flash_ctl_s CTL_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0};

endpackage

// >>> flash_host.sv
// Contract
// - Suspended: ready high, polling bit 1, toggle frozen; host reads erasing sector.
// - Host may program unsuspended sectors while suspended; reported as normal program.
// - Erase polling valid after last erase write; host polls an unprotected erasing sector.
// - Polling bit may settle before others; host repeats the read for a full byte.
`timescale 1ns/1ps
`default_nettype none

module flash_host #(
  parameter logic [7:0] SUSPEND_CODE = 8'hB0,
  parameter int POLL_LIMIT = 1000000
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [19:0] o_flash_addr,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  output logic o_chip_select_n,
  output logic o_output_enable_n,
  output logic o_write_strobe_n,
  input wire logic i_ready_busy_n
);

  // Refuse settings the poll loop or the command decode cannot serve
  if (POLL_LIMIT < 2 || SUSPEND_CODE == flash_host_pkg::RESUME_CODE) begin : g_bad_param
    $error("flash_host parameter out of range");
  end

  // Pin synchronisers
  logic [7:0] dq_s1_r, dq_s2_r;
  logic rdy_s1_r, rdy_s2_r;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
      rdy_s1_r <= 1'b1;
      rdy_s2_r <= 1'b1;
    end else begin
      dq_s1_r <= i_dq;
      dq_s2_r <= dq_s1_r;
      rdy_s1_r <= i_ready_busy_n;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  flash_host_pkg::host_state_e state_r, state_nxt;
  flash_host_pkg::flash_ctl_s ctl_r, ctl_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [2:0] op_r, op_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [7:0] dq_out_r, dq_out_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] prev_r, prev_nxt;
  logic have_prev_r, have_prev_nxt;
  logic final_r, final_nxt;
  logic tmo_r, tmo_nxt;
  logic done_r, done_nxt;
  logic fail_r, fail_nxt;
  logic susp_r, susp_nxt;
  logic after_susp_r, after_susp_nxt;
  logic [31:0] polls_r, polls_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  logic busy, acc, wr_ok, mapped;
  assign busy = (state_r != flash_host_pkg::S_IDLE);
  assign acc = i_psel && i_penable;
  assign mapped = (i_paddr == flash_host_pkg::REG_CTRL) || (i_paddr == flash_host_pkg::REG_ADDR) ||
                  (i_paddr == flash_host_pkg::REG_WDATA) || (i_paddr == flash_host_pkg::REG_STATUS);
  // Writes to control registers are refused while an operation runs
  assign wr_ok = !busy && (i_paddr != flash_host_pkg::REG_STATUS);
  assign o_pready = 1'b1;
  assign o_pslverr = acc && (!mapped || (i_pwrite && !wr_ok));

  function automatic logic [7:0] cyc8(input int n);
    cyc8 = 8'(n - 1);
  endfunction

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    dq_out_nxt = dq_out_r;
    rdata_nxt = rdata_r;
    prev_nxt = prev_r;
    have_prev_nxt = have_prev_r;
    final_nxt = final_r;
    tmo_nxt = tmo_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    susp_nxt = susp_r;
    after_susp_nxt = after_susp_r;
    polls_nxt = polls_r;
    prdata_nxt = prdata_r;

    if (i_psel && !i_penable) begin
      unique case (i_paddr)
        flash_host_pkg::REG_ADDR: prdata_nxt = {12'h000, addr_r};
        flash_host_pkg::REG_WDATA: prdata_nxt = {24'h00_0000, wdata_r};
        flash_host_pkg::REG_STATUS: begin
          prdata_nxt = 32'h0000_0000;
          prdata_nxt[flash_host_pkg::ST_BUSY] = busy;
          prdata_nxt[flash_host_pkg::ST_DONE] = done_r;
          prdata_nxt[flash_host_pkg::ST_FAIL] = fail_r;
          prdata_nxt[flash_host_pkg::ST_SUSP] = susp_r;
          prdata_nxt[flash_host_pkg::ST_RDY] = rdy_s2_r;
          prdata_nxt[flash_host_pkg::ST_TMO] = tmo_r;
          prdata_nxt[flash_host_pkg::ST_DATA_LSB +: 8] = rdata_r;
        end
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end

    if (acc && i_pwrite && wr_ok) begin
      unique case (i_paddr)
        flash_host_pkg::REG_ADDR: addr_nxt = i_pwdata[19:0];
        flash_host_pkg::REG_WDATA: wdata_nxt = i_pwdata[7:0];
        flash_host_pkg::REG_CTRL: begin
          op_nxt = i_pwdata[2:0];
          done_nxt = 1'b0;
          fail_nxt = 1'b0;
          tmo_nxt = 1'b0;
          have_prev_nxt = 1'b0;
          final_nxt = 1'b0;
          after_susp_nxt = (i_pwdata[2:0] == flash_host_pkg::OP_SUSPEND);
          polls_nxt = 32'h0000_0000;
          cnt_nxt = cyc8(flash_host_pkg::WE_LOW_CYC);
          unique case (i_pwdata[2:0])
            flash_host_pkg::OP_WRITE: begin
              dq_out_nxt = wdata_r;
              state_nxt = flash_host_pkg::S_WR_LO;
            end
            flash_host_pkg::OP_SUSPEND: begin
              dq_out_nxt = SUSPEND_CODE;
              state_nxt = flash_host_pkg::S_WR_LO;
            end
            flash_host_pkg::OP_RESUME: begin
              dq_out_nxt = flash_host_pkg::RESUME_CODE;
              susp_nxt = 1'b0;
              state_nxt = flash_host_pkg::S_WR_LO;
            end
            flash_host_pkg::OP_READ, flash_host_pkg::OP_POLL: begin
              cnt_nxt = cyc8(flash_host_pkg::ACCESS_CYC);
              state_nxt = flash_host_pkg::S_RD_LO;
            end
            default: begin
              fail_nxt = 1'b1;
              done_nxt = 1'b1;
            end
          endcase
        end
        default: ;
      endcase
    end

    unique case (state_r)
      flash_host_pkg::S_IDLE: ;
      flash_host_pkg::S_WR_LO: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h00) begin
          cnt_nxt = cyc8(flash_host_pkg::WE_HIGH_CYC);
          state_nxt = flash_host_pkg::S_WR_HI;
        end
      end
      flash_host_pkg::S_WR_HI: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h00) begin
          if (op_r == flash_host_pkg::OP_SUSPEND) begin
            // Wait for the device to settle into suspension
            op_nxt = flash_host_pkg::OP_POLL;
            cnt_nxt = cyc8(flash_host_pkg::ACCESS_CYC);
            state_nxt = flash_host_pkg::S_RD_LO;
          end else begin
            done_nxt = 1'b1;
            state_nxt = flash_host_pkg::S_IDLE;
          end
        end
      end
      flash_host_pkg::S_RD_LO: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h00) begin
          rdata_nxt = dq_s2_r;
          cnt_nxt = cyc8(flash_host_pkg::OE_HIGH_CYC);
          state_nxt = flash_host_pkg::S_RD_HI;
        end
      end
      flash_host_pkg::S_RD_HI: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h00) begin
          state_nxt = flash_host_pkg::S_EVAL;
        end
      end
      flash_host_pkg::S_EVAL: begin
        cnt_nxt = cyc8(flash_host_pkg::ACCESS_CYC);
        state_nxt = flash_host_pkg::S_RD_LO;
        polls_nxt = polls_r + 32'h0000_0001;
        prev_nxt = rdata_r;
        have_prev_nxt = 1'b1;
        if (op_r != flash_host_pkg::OP_POLL || final_r) begin
          // Confirming read after status settled gives the full byte
          done_nxt = 1'b1;
          if (after_susp_r) begin
            susp_nxt = rdata_r[flash_host_pkg::POLL_BIT];
          end
          state_nxt = flash_host_pkg::S_IDLE;
        end else if (have_prev_r && prev_r[flash_host_pkg::TOGGLE_BIT] == rdata_r[flash_host_pkg::TOGGLE_BIT]) begin
          final_nxt = 1'b1;
        end else if (have_prev_r && tmo_r) begin
          // Still toggling after the fail bit was seen
          fail_nxt = 1'b1;
          done_nxt = 1'b1;
          state_nxt = flash_host_pkg::S_IDLE;
        end else if (polls_r >= 32'(POLL_LIMIT)) begin
          fail_nxt = 1'b1;
          done_nxt = 1'b1;
          state_nxt = flash_host_pkg::S_IDLE;
        end else if (rdata_r[flash_host_pkg::TMO_BIT] && !tmo_r) begin
          // Read twice more before declaring failure
          tmo_nxt = 1'b1;
          have_prev_nxt = 1'b0;
        end
      end
    endcase

    ctl_nxt = flash_host_pkg::CTL_IDLE;
    unique case (state_nxt)
      flash_host_pkg::S_WR_LO: begin
        ctl_nxt.ce_n = 1'b0;
        ctl_nxt.we_n = 1'b0;
        ctl_nxt.dq_oe = 1'b1;
      end
      flash_host_pkg::S_WR_HI: begin
        ctl_nxt.dq_oe = 1'b1;
      end
      flash_host_pkg::S_RD_LO: begin
        // While the device is busy, each separate output enable pulse advances the toggle bit
        ctl_nxt.ce_n = 1'b0;
        ctl_nxt.oe_n = 1'b0;
      end
      default: ;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= flash_host_pkg::S_IDLE;
      ctl_r <= flash_host_pkg::CTL_IDLE;
      cnt_r <= 8'h00;
      op_r <= flash_host_pkg::OP_WRITE;
      addr_r <= flash_host_pkg::ADDR_RST;
      wdata_r <= flash_host_pkg::DATA_RST;
      dq_out_r <= flash_host_pkg::DATA_RST;
      rdata_r <= flash_host_pkg::DATA_RST;
      prev_r <= flash_host_pkg::DATA_RST;
      have_prev_r <= 1'b0;
      final_r <= 1'b0;
      tmo_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      susp_r <= 1'b0;
      after_susp_r <= 1'b0;
      polls_r <= 32'h0000_0000;
      prdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      ctl_r <= ctl_nxt;
      cnt_r <= cnt_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      dq_out_r <= dq_out_nxt;
      rdata_r <= rdata_nxt;
      prev_r <= prev_nxt;
      have_prev_r <= have_prev_nxt;
      final_r <= final_nxt;
      tmo_r <= tmo_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      susp_r <= susp_nxt;
      after_susp_r <= after_susp_nxt;
      polls_r <= polls_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Address held for the whole cycle; software points polls at the erasing sector
  assign o_flash_addr = addr_r;
  assign o_dq = dq_out_r;
  assign o_dq_oe = ctl_r.dq_oe;
  assign o_chip_select_n = ctl_r.ce_n;
  assign o_output_enable_n = ctl_r.oe_n;
  assign o_write_strobe_n = ctl_r.we_n;
  assign o_prdata = prdata_r;

endmodule // flash_host

`default_nettype wire

// >>> flash_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_asserts (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [19:0] o_flash_addr,
  input wire logic o_dq_oe,
  input wire logic o_chip_select_n,
  input wire logic o_output_enable_n,
  input wire logic o_write_strobe_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic acc;
  assign acc = i_psel && i_penable;
  sequence wr_low; (!o_write_strobe_n) [*7]; endsequence
  sequence rd_low; !o_output_enable_n ##19 !o_output_enable_n; endsequence
  pready_high_a: assert property (acc |-> o_pready) else $error("pready low in access");
  unmapped_err_a: assert property (acc && !(i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}) |-> o_pslverr)
    else $error("unmapped access without error");
  status_ro_a: assert property (acc && i_pwrite && i_paddr == 8'h0C |-> o_pslverr) else $error("status write taken");
  addr_load_a: assert property (acc && i_pwrite && i_paddr == 8'h04 && !o_pslverr |=>
    o_flash_addr == $past(i_pwdata[19:0])) else $error("flash address not loaded");
  we_width_a: assert property ($fell(o_write_strobe_n) |-> wr_low ##1 o_write_strobe_n)
    else $error("write strobe width wrong");
  we_qual_a: assert property (!o_write_strobe_n |-> o_dq_oe && !o_chip_select_n && o_output_enable_n)
    else $error("write strobe without data drive");
  data_hold_a: assert property ($rose(o_write_strobe_n) |-> o_dq_oe [*4] ##1 !o_dq_oe)
    else $error("data hold after strobe wrong");
  oe_width_a: assert property ($fell(o_output_enable_n) |-> rd_low ##1 o_output_enable_n)
    else $error("read strobe width wrong");
  no_contend_a: assert property (!o_output_enable_n |-> !o_dq_oe && !o_chip_select_n)
    else $error("host drives during read");
  addr_hold_a: assert property (!o_write_strobe_n ##1 !o_write_strobe_n |-> $stable(o_flash_addr))
    else $error("address moved during write");
endmodule // flash_host_asserts
bind flash_host flash_host_asserts chk (.i_clock, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_pready, .o_pslverr, .o_flash_addr, .o_dq_oe, .o_chip_select_n, .o_output_enable_n, .o_write_strobe_n);
`default_nettype wire

// >>> flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] SUSPEND_CODE = 8'hB0,
  parameter logic [3:0] ERASE_SECTOR = 4'h3,
  parameter int WIN_NS = 50000
) (
  input wire logic i_output_enable_n,
  input wire logic i_write_strobe_n,
  input wire logic [19:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_start_erase,
  input wire logic i_fail,
  output logic [7:0] o_dq,
  output logic o_ready_busy_n
);
  typedef enum {M_READ, M_PROG, M_WIN, M_ERASE, M_SUSP, M_ESP} mode_e;
  mode_e mode = M_READ;
  logic tog = 1'h0;
  logic tog2 = 1'h0;
  logic drive = 1'h0;
  logic armed = 1'h0;
  logic [7:0] pdata = 8'h00;
  logic [7:0] last = 8'h00;
  logic [19:0] pa = 20'h0_0000;
  int left = 0;
  // Released bus shows the inverse of the last byte
  assign o_dq = drive ? last : ~last;
  assign o_ready_busy_n = (mode inside {M_PROG, M_ESP, M_WIN, M_ERASE}) ? 1'h0 : 1'h1;
  // Acceptance window before the erase proper starts
  always begin
    @(posedge i_start_erase);
    mode = M_WIN;
    #(WIN_NS);
    if (mode == M_WIN) mode = M_ERASE;
  end
  // Reset takes the strobe from unknown to high; only a full pulse is a write
  always @(negedge i_write_strobe_n) armed = 1'h1;
  always @(posedge i_write_strobe_n) if (armed) begin
    armed = 1'h0;
    if ((mode == M_ERASE || mode == M_WIN) && i_dq == SUSPEND_CODE) begin
      mode = M_SUSP;
      tog = ~tog;
    end else if (mode == M_SUSP && i_dq == flash_host_pkg::RESUME_CODE) begin
      mode = M_ERASE;
      tog = ~tog;
    end else if (mode == M_SUSP && i_dq != SUSPEND_CODE && i_addr[19:16] != ERASE_SECTOR) begin
      mode = M_ESP;
      pdata = i_dq;
      pa = i_addr;
      left = 3;
    end else if (mode == M_READ) begin
      mode = M_PROG;
      pdata = i_dq;
      pa = i_addr;
      left = 3;
    end // Others dropped
  end
  always @(posedge i_output_enable_n) drive = 1'h0;
  always @(negedge i_output_enable_n) begin
    drive = 1'h1;
    case (mode)
      M_PROG, M_ESP: begin
        last = {~pdata[7], tog, i_fail, 2'h0, 1'h1, 2'h0};
        tog = ~tog;
        left--;
        if (left == 0) mode = (mode == M_ESP) ? M_SUSP : M_READ;
      end
      M_ERASE, M_WIN: begin
        last = {1'h0, tog, i_fail, 1'h0, mode == M_ERASE, tog2, 2'h0};
        tog = ~tog;
        tog2 = ~tog2;
      end
      M_SUSP: begin
        last = (i_addr[19:16] == ERASE_SECTOR) ? {1'h1, tog, 3'h0, tog2, 2'h0} :
          ((i_addr == pa) ? pdata : i_addr[7:0]);
        tog2 = ~tog2;
      end
      default: last = (i_addr == pa) ? pdata : i_addr[7:0];
    endcase
  end
endmodule // flash_dev_model
`default_nettype wire

// >>> test_flash_host.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_host;
  logic i_clock = 1'h0;
  logic i_sys_rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic start_erase = 1'h0;
  logic fail_inj = 1'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, dq_oe, ce_n, oe_n, we_n, rb_n, b6;
  logic [19:0] faddr;
  logic [7:0] hdq;
  logic [7:0] mdq;
  wire logic [7:0] dq_bus = dq_oe ? hdq : mdq;
  int num_errors = 0;
  int compares = 0;
  initial forever #2.5 i_clock = ~i_clock;
  flash_host #(.POLL_LIMIT(20)) dut (.i_clock, .i_sys_rst, .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_flash_addr(faddr), .i_dq(dq_bus), .o_dq(hdq), .o_dq_oe(dq_oe), .o_chip_select_n(ce_n),
    .o_output_enable_n(oe_n), .o_write_strobe_n(we_n), .i_ready_busy_n(rb_n));
  flash_dev_model dev (.i_output_enable_n(oe_n), .i_write_strobe_n(we_n), .i_addr(faddr), .i_dq(dq_bus),
    .i_start_erase(start_erase), .i_fail(fail_inj), .o_dq(mdq), .o_ready_busy_n(rb_n));
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'h1;
    do @(posedge i_clock); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic run_op(input logic [2:0] op);
    apb(1'h1, flash_host_pkg::REG_CTRL, {29'h0000_0000, op});
    for (int i = 0; i < 4000; i++) begin
      apb(1'h0, flash_host_pkg::REG_STATUS, 32'h0000_0000);
      if (rd[flash_host_pkg::ST_BUSY] === 1'h0) break;
    end
  endtask
  task automatic t_regs();
    apb(1'h0, flash_host_pkg::REG_ADDR, 32'h0000_0000);
    chk("addr reset", rd, 32'h0000_0000);
    apb(1'h1, 8'h10, 32'h0000_0001);
    chk("unmapped error", err, 1'h1);
    apb(1'h0, 8'h14, 32'h0000_0000);
    chk("unmapped data", rd, 32'h0000_0000);
    apb(1'h1, flash_host_pkg::REG_STATUS, 32'hFFFF_FFFF);
    chk("status write error", err, 1'h1);
    run_op(3'h5);
    chk("bad op done fail", rd[2:1], 2'h3);
    $display("test regs done");
  endtask
  task automatic t_prog();
    apb(1'h1, flash_host_pkg::REG_ADDR, 32'h0001_0010);
    apb(1'h1, flash_host_pkg::REG_WDATA, 32'h0000_005A);
    run_op(flash_host_pkg::OP_WRITE);
    run_op(flash_host_pkg::OP_READ);
    chk("prog poll bit", rd[15], 1'h1);
    chk("prog busy pin", rd[flash_host_pkg::ST_RDY], 1'h0);
    b6 = rd[14];
    run_op(flash_host_pkg::OP_READ);
    chk("prog toggle", rd[14], !b6);
    run_op(flash_host_pkg::OP_SUSPEND);
    chk("prog suspend ignored", rd[flash_host_pkg::ST_SUSP], 1'h0);
    chk("prog final byte", rd[15:8], 8'h5A);
    $display("test prog done");
  endtask
  task automatic t_erase();
    apb(1'h1, flash_host_pkg::REG_ADDR, 32'h0003_1234);
    start_erase <= 1'h1;
    run_op(flash_host_pkg::OP_READ);
    chk("window poll bit", rd[15], 1'h0);
    chk("window open", rd[11], 1'h0);
    b6 = rd[14];
    run_op(flash_host_pkg::OP_READ);
    chk("window toggle", rd[14], !b6);
    repeat (10000) @(posedge i_clock);
    run_op(flash_host_pkg::OP_READ);
    chk("erase poll bit", rd[15], 1'h0);
    chk("erase window", rd[11], 1'h1);
    b6 = rd[14];
    run_op(flash_host_pkg::OP_READ);
    chk("erase toggle", rd[14], !b6);
    for (int k = 0; k < 2; k++) begin
      run_op(flash_host_pkg::OP_SUSPEND);
      chk("suspended", rd[flash_host_pkg::ST_SUSP], 1'h1);
      chk("suspended pin", rd[flash_host_pkg::ST_RDY], 1'h1);
    end
    run_op(flash_host_pkg::OP_READ);
    b6 = rd[14];
    run_op(flash_host_pkg::OP_READ);
    chk("frozen toggle", rd[14], b6);
    apb(1'h1, flash_host_pkg::REG_ADDR, 32'h0000_0055);
    run_op(flash_host_pkg::OP_READ);
    chk("other sector data", rd[15:8], 8'h55);
    apb(1'h1, flash_host_pkg::REG_WDATA, 32'h0000_0085);
    run_op(flash_host_pkg::OP_WRITE);
    run_op(flash_host_pkg::OP_READ);
    chk("susp prog status", {rd[15], rd[13], rd[11], rd[10], rd[flash_host_pkg::ST_RDY]}, 5'h02);
    run_op(flash_host_pkg::OP_POLL);
    chk("susp prog data", rd[15:8], 8'h85);
    apb(1'h1, flash_host_pkg::REG_ADDR, 32'h0003_1234);
    run_op(flash_host_pkg::OP_RESUME);
    chk("resume clears", rd[flash_host_pkg::ST_SUSP], 1'h0);
    run_op(flash_host_pkg::OP_READ);
    chk("erasing again", rd[15], 1'h0);
    run_op(flash_host_pkg::OP_SUSPEND);
    chk("suspend again", rd[flash_host_pkg::ST_SUSP], 1'h1);
    run_op(flash_host_pkg::OP_RESUME);
    fail_inj <= 1'h1;
    run_op(flash_host_pkg::OP_POLL);
    chk("timeout fail", {rd[flash_host_pkg::ST_TMO], rd[flash_host_pkg::ST_FAIL]}, 2'h3);
    $display("test erase done");
  endtask
  task automatic final_report();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'h0;
    t_regs();
    t_prog();
    t_erase();
    final_report();
  end
endmodule // test_flash_host
`default_nettype wire
